// [sed_regs.sv]
module sed_regs #(
  parameter int N = sed_pkg::NUM_LANES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [sed_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic scan_run_flag,
  input wire logic [sed_pkg::MODE_W-1:0] scan_mode_select,
  input wire logic [sed_pkg::LEN_W-1:0] scan_length_code,
  input wire logic signal_loss_detect_enable,
  input wire logic [N-1:0] lane_mismatch_hit,
  input wire logic [N-1:0] lane_scan_finish,
  input wire logic [N*sed_pkg::OFFSET_W-1:0] lane_auto_offset_value,
  input wire logic [sed_pkg::PHASE_W-1:0] recovery_phase_value,
  output logic [sed_pkg::SLOT_W-1:0] eye_scan_bit_slot,
  output logic scan_sample_en,
  output logic [sed_pkg::TOTAL_W-1:0] scan_sample_total,
  output logic [sed_pkg::MV_W-1:0] signal_loss_mv,
  output logic [sed_pkg::VOTES_W-1:0] equalizer_votes,
  output logic recovery_phase_freeze
);
  import sed_pkg::*;

  sed_lane_if #(.N(N)) lif ();

  logic [SLOT_W-1:0] slot_r, slot_nxt;
  logic clr_bit_r, clr_bit_nxt;
  sed_clr_state_t clr_state_r, clr_state_nxt;
  logic clear_pulse_r, clear_pulse_nxt;
  logic [LOSS_W-1:0] loss_r, loss_nxt;
  logic [VOTE_W-1:0] vote_r, vote_nxt;
  logic freeze_r, freeze_nxt;
  logic [SLOT_W-1:0] slot_ctr_r, slot_ctr_nxt;
  logic sample_en_r, sample_en_nxt;
  logic [TOTAL_W-1:0] total_r, total_nxt;
  logic [MV_W-1:0] loss_mv_r, loss_mv_nxt;
  logic [VOTES_W-1:0] votes_r, votes_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [ADDR_W-1:0] rel;
  logic [3:0] lane;

  ////////////////////////////////////////////////////////////////////////////
  // lane results
  assign lif.scan_run = scan_run_flag;
  assign lif.clear_pulse = clear_pulse_r;
  assign lif.mode = scan_mode_select;
  assign lif.hit = lane_mismatch_hit;
  assign lif.finish = lane_scan_finish;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      lif.offset_in[i] = lane_auto_offset_value[i*OFFSET_W +: OFFSET_W];
    end
  end

  sed_lane_results #(.N(N)) sed_lane_results_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .lif(lif.lanes)
  );

  ////////////////////////////////////////////////////////////////////////////
  // software-writable registers and counter clear sequence
  always_comb begin
    slot_nxt = slot_r;
    clr_bit_nxt = clr_bit_r;
    loss_nxt = loss_r;
    vote_nxt = vote_r;
    freeze_nxt = freeze_r;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_BIT_SLOT: slot_nxt = reg_wdata[SLOT_W-1:0];
        OFS_CNT_CLR: clr_bit_nxt = reg_wdata[0];
        OFS_LOSS: loss_nxt = reg_wdata[LOSS_W-1:0];
        OFS_VOTE: vote_nxt = reg_wdata[VOTE_W-1:0];
        OFS_FREEZE: freeze_nxt = reg_wdata[0];
        default: ;
      endcase
    end
    clr_state_nxt = clr_state_r;
    clear_pulse_nxt = 1'b0;
    unique case (clr_state_r)
      CLR_IDLE: if (clr_bit_r) begin
        clr_state_nxt = CLR_ARMED;
      end
      CLR_ARMED: if (!clr_bit_r) begin
        clr_state_nxt = CLR_IDLE;
        clear_pulse_nxt = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sampler slot, decoded settings
  always_comb begin
    slot_ctr_nxt = (slot_ctr_r == LAST_SLOT) ? 5'h00 : slot_ctr_r + 5'h01;
    sample_en_nxt = scan_run_flag && slot_ctr_r == slot_r;
    total_nxt = sed_sample_total(scan_length_code);
    votes_nxt = sed_vote_count(vote_r);
    loss_mv_nxt = 8'h00;
    if (signal_loss_detect_enable && loss_r >= LOSS_MIN_CODE) begin
      loss_mv_nxt = MV_W'(LOSS_MV_STEP * loss_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port
  always_comb begin
    rel = '0;
    lane = '0;
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      rdata_nxt = 8'h00;
      if (reg_addr >= OFS_OFFSET_BASE && reg_addr < OFS_TALLY_BASE) begin
        rel = reg_addr - OFS_OFFSET_BASE;
        lane = rel[3:0];
        rdata_nxt = {2'h0, lif.offset_q[lane]};
      end else if (reg_addr >= OFS_TALLY_BASE &&
          reg_addr < OFS_TALLY_BASE + 12'h020) begin
        rel = reg_addr - OFS_TALLY_BASE;
        lane = rel[4:1];
        rdata_nxt = rel[0] ? lif.tally_q[lane][15:8] :
          lif.tally_q[lane][7:0];
      end else begin
        unique case (reg_addr)
          OFS_BIT_SLOT: rdata_nxt = {3'h0, slot_r};
          OFS_CNT_CLR: rdata_nxt = {7'h00, clr_bit_r};
          OFS_DONE_LO: rdata_nxt = lif.done[7:0];
          OFS_DONE_HI: rdata_nxt = lif.done[15:8];
          OFS_LOSS: rdata_nxt = {4'h0, loss_r};
          OFS_VOTE: rdata_nxt = {4'h0, vote_r};
          OFS_FREEZE: rdata_nxt = {7'h00, freeze_r};
          OFS_PHASE: rdata_nxt = recovery_phase_value;
          default: rdata_nxt = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      slot_r <= RST_BIT_SLOT;
      clr_bit_r <= RST_CNT_CLR;
      clr_state_r <= CLR_IDLE;
      clear_pulse_r <= 1'b0;
      loss_r <= RST_LOSS;
      vote_r <= RST_VOTE;
      freeze_r <= RST_FREEZE;
      slot_ctr_r <= 5'h00;
      sample_en_r <= 1'b0;
      total_r <= 17'h0007F;
      loss_mv_r <= 8'h00;
      votes_r <= 9'h1FF;
      rdata_r <= 8'h00;
    end else begin
      slot_r <= slot_nxt;
      clr_bit_r <= clr_bit_nxt;
      clr_state_r <= clr_state_nxt;
      clear_pulse_r <= clear_pulse_nxt;
      loss_r <= loss_nxt;
      vote_r <= vote_nxt;
      freeze_r <= freeze_nxt;
      slot_ctr_r <= slot_ctr_nxt;
      sample_en_r <= sample_en_nxt;
      total_r <= total_nxt;
      loss_mv_r <= loss_mv_nxt;
      votes_r <= votes_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign eye_scan_bit_slot = slot_r;
  assign scan_sample_en = sample_en_r;
  assign scan_sample_total = total_r;
  assign signal_loss_mv = loss_mv_r;
  assign equalizer_votes = votes_r;
  assign recovery_phase_freeze = freeze_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_SLOT_WRAP: assert property (
    slot_ctr_r == 5'h13 |=> slot_ctr_r == 5'h00)
    else $error("slot counter did not wrap after twenty");
  AST_SAMPLE_SLOT: assert property (
    sample_en_r |-> $past(slot_ctr_r) == $past(slot_r) &&
      $past(scan_run_flag))
    else $error("sample strobe outside selected slot");
  AST_CLEAR_SEQ: assert property (
    clr_bit_r ##1 !clr_bit_r |=> clear_pulse_r ##1 !clear_pulse_r)
    else $error("one-then-zero did not give a single clear pulse");
  AST_LOSS_MV: assert property (
    signal_loss_detect_enable && loss_r == 4'h4 |=> signal_loss_mv == 8'h3C)
    else $error("loss threshold code 4 is not 60 mV");
  AST_VOTES: assert property (
    vote_r == 4'h0 |=> equalizer_votes == 9'h1FF)
    else $error("vote code 0 is not 511 votes");
  AST_FREEZE: assert property (
    reg_wr && reg_addr == OFS_FREEZE |=>
      recovery_phase_freeze == $past(reg_wdata[0]))
    else $error("freeze output did not follow write");
  AST_DONE_READ: assert property (
    reg_rd && reg_addr == OFS_DONE_HI |=> reg_rdata == $past(lif.done[15:8]))
    else $error("completion high byte readback wrong");
  AST_TALLY_READ: assert property (
    reg_rd && reg_addr == OFS_TALLY_BASE |=>
      reg_rdata == $past(lif.tally_q[0][7:0]))
    else $error("lane 0 tally not at lowest address");
  AST_LEN: assert property (
    scan_length_code == 2'h1 |=> scan_sample_total == 17'h00408)
    else $error("length code 1 is not 1032 samples");
endmodule

// [sed_pkg.sv]
package sed_pkg;
  localparam int NUM_LANES = 16;
  localparam int ADDR_W = 12;
  localparam int SLOT_W = 5;
  localparam int OFFSET_W = 6;
  localparam int TALLY_W = 16;
  localparam int LOSS_W = 4;
  localparam int VOTE_W = 4;
  localparam int PHASE_W = 8;
  localparam int MODE_W = 4;
  localparam int LEN_W = 2;
  localparam int TOTAL_W = 17;
  localparam int VOTES_W = 9;
  localparam int MV_W = 8;
  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_BIT_SLOT = 12'h1F4;
  localparam logic [ADDR_W-1:0] OFS_CNT_CLR = 12'h1F5;
  localparam logic [ADDR_W-1:0] OFS_DONE_LO = 12'h1F6;
  localparam logic [ADDR_W-1:0] OFS_DONE_HI = 12'h1F7;
  localparam logic [ADDR_W-1:0] OFS_OFFSET_BASE = 12'h200;
  localparam logic [ADDR_W-1:0] OFS_TALLY_BASE = 12'h210;
  localparam logic [ADDR_W-1:0] OFS_LOSS = 12'h234;
  localparam logic [ADDR_W-1:0] OFS_VOTE = 12'h235;
  localparam logic [ADDR_W-1:0] OFS_FREEZE = 12'h238;
  localparam logic [ADDR_W-1:0] OFS_PHASE = 12'h239;
  ////////////////////////////////////////////////////////////////////////////
  // reset values and field constants
  localparam logic [SLOT_W-1:0] RST_BIT_SLOT = 5'h00;
  localparam logic RST_CNT_CLR = 1'b0;
  localparam logic [LOSS_W-1:0] RST_LOSS = 4'h8;
  localparam logic [VOTE_W-1:0] RST_VOTE = 4'h0;
  localparam logic RST_FREEZE = 1'b0;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 5'h13;
  localparam logic [LOSS_W-1:0] LOSS_MIN_CODE = 4'h2;
  localparam logic [MV_W-1:0] LOSS_MV_STEP = 8'h0F;
  localparam logic [TALLY_W-1:0] TALLY_MAX = 16'hFFFF;

  typedef enum logic {CLR_IDLE = 1'b0, CLR_ARMED = 1'b1} sed_clr_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // decoders
  function automatic logic [VOTES_W-1:0] sed_vote_count(
      input logic [VOTE_W-1:0] code);
    logic [VOTES_W:0] v;
    v = 10'h000;
    if (code == 4'h0) begin
      v = 10'h1FF;
    end else if (code >= 4'h2 && code <= 4'h9) begin
      v = (10'h001 << (code - 4'h1)) - 10'h001;
    end
    return v[VOTES_W-1:0];
  endfunction

  function automatic logic [TOTAL_W-1:0] sed_sample_total(
      input logic [LEN_W-1:0] len);
    unique case (len)
      2'h0: return 17'h0007F;
      2'h1: return 17'h00408;
      2'h2: return 17'h01FFF;
      2'h3: return 17'h0FFFF;
    endcase
  endfunction

  function automatic logic sed_mode_counts(input logic [MODE_W-1:0] m);
    return (m >= 4'h1 && m <= 4'h4);
  endfunction

  function automatic logic sed_mode_auto(input logic [MODE_W-1:0] m);
    return (m >= 4'h8 && m <= 4'hE && m != 4'hB);
  endfunction
endpackage

// [sed_lane_if.sv]
interface sed_lane_if #(parameter int N = 16);
  logic scan_run;
  logic clear_pulse;
  logic [3:0] mode;
  logic [N-1:0] hit;
  logic [N-1:0] finish;
  logic [5:0] offset_in [N];
  logic [N-1:0] done;
  logic [5:0] offset_q [N];
  logic [15:0] tally_q [N];
  modport ctrl (output scan_run, clear_pulse, mode, hit, finish, offset_in,
    input done, offset_q, tally_q);
  modport lanes (input scan_run, clear_pulse, mode, hit, finish, offset_in,
    output done, offset_q, tally_q);
endinterface

// [sed_lane_results.sv]
module sed_lane_results #(
  parameter int N = sed_pkg::NUM_LANES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  sed_lane_if.lanes lif
);
  import sed_pkg::*;

  logic run_d_r, run_d_nxt;
  logic [N-1:0] done_r, done_nxt;
  logic [OFFSET_W-1:0] offset_r [N];
  logic [OFFSET_W-1:0] offset_nxt [N];
  logic [TALLY_W-1:0] tally_r [N];
  logic [TALLY_W-1:0] tally_nxt [N];
  logic start;

  ////////////////////////////////////////////////////////////////////////////
  // per-lane completion, offset and tally
  always_comb begin
    start = lif.scan_run && !run_d_r;
    run_d_nxt = lif.scan_run;
    for (int i = 0; i < N; i++) begin
      done_nxt[i] = done_r[i];
      offset_nxt[i] = offset_r[i];
      tally_nxt[i] = tally_r[i];
      if (lif.scan_run && lif.finish[i]) begin
        done_nxt[i] = 1'b1;
      end else if (start) begin
        done_nxt[i] = 1'b0;
      end
      if (lif.scan_run && lif.finish[i] && !done_r[i] &&
          sed_mode_auto(lif.mode)) begin
        offset_nxt[i] = lif.offset_in[i];
      end
      if (lif.clear_pulse) begin
        tally_nxt[i] = '0;
      end else if (lif.scan_run && !done_r[i] && lif.hit[i] &&
          sed_mode_counts(lif.mode) && tally_r[i] != TALLY_MAX) begin
        tally_nxt[i] = tally_r[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_d_r <= 1'b0;
      done_r <= '0;
      for (int i = 0; i < N; i++) begin
        offset_r[i] <= '0;
        tally_r[i] <= '0;
      end
    end else begin
      run_d_r <= run_d_nxt;
      done_r <= done_nxt;
      offset_r <= offset_nxt;
      tally_r <= tally_nxt;
    end
  end

  assign lif.done = done_r;
  assign lif.offset_q = offset_r;
  assign lif.tally_q = tally_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_DONE_HOLD: assert property (
    done_r[0] && !(lif.scan_run && !run_d_r) |=> done_r[0])
    else $error("lane 0 completion dropped without a new scan");
  AST_TALLY_CLEAR: assert property (
    lif.clear_pulse |=> tally_r[0] == 16'h0000)
    else $error("tally not cleared by clear pulse");
  AST_OFFSET_HOLD: assert property (
    done_r[0] && !(lif.scan_run && !run_d_r) |=> $stable(offset_r[0]))
    else $error("offset result moved after completion");
  AST_TALLY_FROZEN: assert property (
    done_r[0] && !lif.clear_pulse |=> $stable(tally_r[0]))
    else $error("tally moved after completion");
endmodule

// [serdes_eye_scan_debug_regs_bench.sv]
module serdes_eye_scan_debug_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sed_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic run = 1'b0;
  logic [MODE_W-1:0] mode = '0;
  logic [LEN_W-1:0] len = '0;
  logic loss_en = 1'b0;
  logic [NUM_LANES-1:0] hit = '0;
  logic [NUM_LANES-1:0] fin = '0;
  logic [NUM_LANES*OFFSET_W-1:0] ofs = '0;
  logic [PHASE_W-1:0] phase = '0;
  logic [SLOT_W-1:0] slot;
  logic sample_en;
  logic [TOTAL_W-1:0] total;
  logic [MV_W-1:0] loss_mv;
  logic [VOTES_W-1:0] votes;
  logic freeze;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int pulses = 0;
  int p0 = 0;
  int tot_tab [4] = '{127, 1032, 8191, 65535};
  int slot_tab [3] = '{0, 19, 20};

  sed_regs sed_regs_inst (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scan_run_flag(run),
    .scan_mode_select(mode), .scan_length_code(len),
    .signal_loss_detect_enable(loss_en), .lane_mismatch_hit(hit),
    .lane_scan_finish(fin), .lane_auto_offset_value(ofs),
    .recovery_phase_value(phase), .eye_scan_bit_slot(slot),
    .scan_sample_en(sample_en), .scan_sample_total(total),
    .signal_loss_mv(loss_mv), .equalizer_votes(votes),
    .recovery_phase_freeze(freeze));

  always #20 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [16:0] e,
      input logic [16:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    @(negedge core_clk);
  endtask
  task automatic rc(input string nm, input logic [ADDR_W-1:0] a,
      input logic [15:0] e, input int nb);
    logic [7:0] lo;
    logic [7:0] hi = 8'h00;
    rd(a, lo);
    if (nb > 1) rd(a + 12'h001, hi);
    chk(nm, {1'b0, e}, {1'b0, hi, lo});
  endtask
  task automatic events(input logic [15:0] h, input logic [15:0] f, int n);
    hit = h;
    fin = f;
    repeat (n) @(negedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (sample_en === 1'b1) begin
      pulses <= pulses + 1;
    end
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    rc("slot reset", OFS_BIT_SLOT, 16'h0000, 1);
    rc("clear reset", OFS_CNT_CLR, 16'h0000, 1);
    rc("loss reset", OFS_LOSS, 16'h0008, 1);
    rc("vote reset", OFS_VOTE, 16'h0000, 1);
    rc("freeze reset", OFS_FREEZE, 16'h0000, 1);
    chk("loss mv disabled", 8'h00, loss_mv);
    chk("votes reset", 17'd511, votes);
    wr(OFS_BIT_SLOT, 8'hFF);
    rc("slot reserved", OFS_BIT_SLOT, 16'h001F, 1);
    chk("slot out", 17'h0001F, slot);
    for (int i = 0; i < 3; i++) begin
      run = 1'b0;
      wr(OFS_BIT_SLOT, 8'(slot_tab[i]));
      run = 1'b1;
      repeat (5) @(negedge core_clk);
      p0 = pulses;
      repeat (40) @(negedge core_clk);
      chk("sample pulses", (i < 2) ? 17'd2 : 17'd0, 17'(pulses - p0));
    end
    run = 1'b0;
    for (int c = 0; c < 4; c++) begin
      len = 2'(c);
      repeat (2) @(negedge core_clk);
      chk("sample total", 17'(tot_tab[c]), total);
    end
    loss_en = 1'b1;
    for (int c = 0; c < 16; c++) begin
      wr(OFS_LOSS, 8'(c));
      repeat (2) @(negedge core_clk);
      chk("loss mv", (c >= 2) ? 17'(15 * c) : 17'd0, loss_mv);
      wr(OFS_VOTE, 8'(c));
      repeat (2) @(negedge core_clk);
      chk("votes", (c == 0) ? 17'd511 : (c >= 2 && c <= 9) ?
        17'((1 << (c - 1)) - 1) : 17'd0, votes);
    end
    wr(OFS_FREEZE, 8'h01);
    rc("freeze reg", OFS_FREEZE, 16'h0001, 1);
    chk("freeze out", 1'b1, freeze);
    wr(OFS_FREEZE, 8'h00);
    chk("unfreeze out", 1'b0, freeze);
    phase = 8'hA5;
    rc("phase", OFS_PHASE, 16'h00A5, 1);
    rc("unmapped", 12'h300, 16'h0000, 1);
    // counting scan: lane 0 finishes early, lane 5 keeps counting
    mode = 4'h1;
    run = 1'b1;
    repeat (2) @(negedge core_clk);
    events(16'h0021, 16'h0000, 3);
    events(16'h0001, 16'h0000, 1);
    events(16'h0000, 16'h0001, 1);
    events(16'h0021, 16'h0000, 2);
    run = 1'b0;
    events(16'h0021, 16'h0000, 2);
    wr(OFS_DONE_LO, 8'hFF);
    rc("done lanes", OFS_DONE_LO, 16'h0001, 2);
    rc("tally 0", OFS_TALLY_BASE, 16'd4, 2);
    rc("tally 5", OFS_TALLY_BASE + 12'h00A, 16'd5, 2);
    rc("tally 1", OFS_TALLY_BASE + 12'h002, 16'd0, 2);
    wr(OFS_CNT_CLR, 8'h01);
    repeat (3) @(negedge core_clk);
    rc("clear reg", OFS_CNT_CLR, 16'h0001, 1);
    rc("tally armed", OFS_TALLY_BASE, 16'd4, 2);
    wr(OFS_CNT_CLR, 8'h00);
    repeat (4) @(negedge core_clk);
    rc("tally cleared", OFS_TALLY_BASE, 16'd0, 2);
    rc("tally5 clr", OFS_TALLY_BASE + 12'h00A, 16'd0, 2);
    // search scan: offsets captured once per lane
    mode = 4'h8;
    run = 1'b1;
    repeat (2) @(negedge core_clk);
    rc("done new scan", OFS_DONE_LO, 16'h0000, 2);
    for (int n = 0; n < NUM_LANES; n++) begin
      ofs[n*OFFSET_W +: OFFSET_W] = 6'(n * 3 + 7);
    end
    events(16'hFFFF, 16'h0000, 2);
    events(16'h0000, 16'hFFFF, 1);
    ofs = ~ofs;
    events(16'h0000, 16'hFFFF, 1);
    run = 1'b0;
    rc("done all", OFS_DONE_LO, 16'hFFFF, 2);
    rc("tally mode8", OFS_TALLY_BASE + 12'h006, 16'd0, 2);
    for (int n = 0; n < NUM_LANES; n++) begin
      rc("offset", OFS_OFFSET_BASE + 12'(n),
        16'((n * 3 + 7) & 63), 1);
    end
    mode = 4'hB;
    run = 1'b1;
    events(16'h0000, 16'h0000, 1);
    events(16'h0004, 16'h0004, 1);
    rc("reserved mode", OFS_OFFSET_BASE + 12'h002, 16'd13, 1);
    close_out();
  end
endmodule
